// [rtl/dea_pkg.sv]
// package for the data eeprom access controller: register map, fields, timing
// assumes a 32-bit axi4-lite register bus and a 125 MHz core clock
package dea_pkg;
    localparam int ADDR_W = 8;
    localparam int ARRAY_DEPTH = 256;
    localparam logic [7:0] OFS_ACCESS_CONTROL = 8'h00;
    localparam logic [7:0] OFS_UNLOCK_PORT = 8'h04;
    localparam logic [7:0] OFS_CELL_POINTER = 8'h08;
    localparam logic [7:0] OFS_CELL_VALUE = 8'h0C;
    localparam logic [7:0] OFS_DONE_STATUS = 8'h10;
    localparam int BIT_READ_START = 0;
    localparam int BIT_WRITE_START = 1;
    localparam int BIT_PROGRAM_ENABLE = 2;
    localparam int BIT_ABORT = 3;
    localparam int BIT_ARRAY_SELECT = 7;
    localparam int BIT_DONE = 0;
    localparam logic [7:0] UNLOCK_FIRST = 8'h55;
    localparam logic [7:0] UNLOCK_SECOND = 8'hAA;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam int CLK_MHZ = 125;
    localparam int PROG_TIME_US = 4000;
    localparam int PROG_CYCLES = PROG_TIME_US * CLK_MHZ;
    typedef enum logic [1:0] {
        DEA_UNL_IDLE = 2'h0,
        DEA_UNL_FIRST = 2'h1,
        DEA_UNL_ARMED = 2'h3
    } dea_unlock_e;
    typedef struct packed {
        logic valid;
        logic [7:0] offset;
        logic [31:0] data;
        logic [3:0] strb;
    } dea_wreq_s;
endpackage

// [rtl/dea_array.sv]
// byte-wide nonvolatile array model with timed programming
// assumes the controller issues one request at a time and waits for done
`timescale 1ns/1ps
module dea_array #(
    parameter int PROG_CYCLES = dea_pkg::PROG_CYCLES
) (
    input wire logic core_clk, // core clock
    input wire logic rst_n, // synchronous reset, active low
    input wire logic [7:0] rd_addr, // read address
    output logic [7:0] rd_data, // combinational read data
    input wire logic prog_start, // one-cycle program request
    input wire logic [7:0] prog_addr, // program address
    input wire logic [7:0] prog_data, // program data
    output logic prog_busy, // programming in progress
    output logic prog_done // one-cycle completion pulse
);
    logic [7:0] cells [dea_pkg::ARRAY_DEPTH];
    logic [31:0] cnt_reg;
    logic [7:0] addr_reg;
    logic [7:0] data_reg;
    wire cnt_last = (cnt_reg == 32'(PROG_CYCLES - 1));

    assign rd_data = cells[rd_addr];

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            prog_busy <= 1'b0;
            prog_done <= 1'b0;
            cnt_reg <= 32'h0;
            addr_reg <= 8'h00;
            data_reg <= 8'h00;
        end else begin
            prog_done <= 1'b0;
            if (prog_start && !prog_busy) begin
                prog_busy <= 1'b1;
                cnt_reg <= 32'h0;
                addr_reg <= prog_addr;
                data_reg <= prog_data;
            end else if (prog_busy) begin
                cnt_reg <= cnt_reg + 32'h1;
                if (cnt_last) begin
                    prog_busy <= 1'b0;
                    prog_done <= 1'b1;
                end
            end
        end
    end

    // cells survive reset, as nonvolatile storage should
    always_ff @(posedge core_clk) begin
        if (rst_n && prog_busy && cnt_last) begin
            cells[addr_reg] <= data_reg;
        end
    end
endmodule

// [rtl/dea_ctrl.sv]
// data eeprom access controller: axi4-lite registers, unlock, read and write
// assumes one core clock; ext_abort_reset marks a pin or watchdog reset
`timescale 1ns/1ps
module dea_ctrl #(
    parameter int PROG_CYCLES = dea_pkg::PROG_CYCLES
) (
    input wire logic core_clk, // core clock
    input wire logic rst_n, // synchronous reset, active low
    input wire logic por_n, // power-on reset, active low, synchronous
    input wire logic ext_abort_reset, // pin or watchdog reset, high
    input wire logic [7:0] s_axi_awaddr, // write address
    input wire logic s_axi_awvalid, // write address valid
    output logic s_axi_awready, // write address ready
    input wire logic [31:0] s_axi_wdata, // write data
    input wire logic [3:0] s_axi_wstrb, // write strobes
    input wire logic s_axi_wvalid, // write data valid
    output logic s_axi_wready, // write data ready
    output logic [1:0] s_axi_bresp, // write response
    output logic s_axi_bvalid, // write response valid
    input wire logic s_axi_bready, // write response ready
    input wire logic [7:0] s_axi_araddr, // read address
    input wire logic s_axi_arvalid, // read address valid
    output logic s_axi_arready, // read address ready
    output logic [31:0] s_axi_rdata, // read data
    output logic [1:0] s_axi_rresp, // read response
    output logic s_axi_rvalid, // read data valid
    input wire logic s_axi_rready // read data ready
);
    logic aw_held_reg;
    logic w_held_reg;
    logic [7:0] awaddr_reg;
    logic [31:0] wdata_reg;
    logic [3:0] wstrb_reg;
    logic array_select_reg;
    logic program_enable_reg;
    logic write_start_reg;
    logic read_start_reg;
    logic abort_reg;
    logic done_reg;
    logic [7:0] cell_pointer_reg;
    logic [7:0] cell_value_reg;
    dea_pkg::dea_unlock_e unlock_reg;
    dea_pkg::dea_unlock_e unlock_next;
    dea_pkg::dea_wreq_s wreq;
    wire [7:0] arr_rd_data;
    wire arr_busy;
    wire arr_done;

    // write channel capture: address and data in either order
    wire aw_take = s_axi_awvalid && s_axi_awready;
    wire w_take = s_axi_wvalid && s_axi_wready;
    wire aw_have = aw_held_reg || aw_take;
    wire w_have = w_held_reg || w_take;
    wire wr_fire = aw_have && w_have && !s_axi_bvalid;
    assign wreq.valid = wr_fire;
    assign wreq.offset = aw_held_reg ? awaddr_reg : s_axi_awaddr;
    assign wreq.data = w_held_reg ? wdata_reg : s_axi_wdata;
    assign wreq.strb = w_held_reg ? wstrb_reg : s_axi_wstrb;
    wire lane0 = wreq.valid && wreq.strb[0];
    wire [7:0] wbyte = wreq.data[7:0];

    wire ofs_ok = (wreq.offset == dea_pkg::OFS_ACCESS_CONTROL)
        || (wreq.offset == dea_pkg::OFS_UNLOCK_PORT)
        || (wreq.offset == dea_pkg::OFS_CELL_POINTER)
        || (wreq.offset == dea_pkg::OFS_CELL_VALUE)
        || (wreq.offset == dea_pkg::OFS_DONE_STATUS);
    wire wr_ctrl = lane0 && (wreq.offset == dea_pkg::OFS_ACCESS_CONTROL);
    wire wr_unlock = lane0 && (wreq.offset == dea_pkg::OFS_UNLOCK_PORT);
    wire wr_ptr = lane0 && (wreq.offset == dea_pkg::OFS_CELL_POINTER);
    wire wr_val = lane0 && (wreq.offset == dea_pkg::OFS_CELL_VALUE);
    wire wr_done = lane0 && (wreq.offset == dea_pkg::OFS_DONE_STATUS);

    // launch decisions
    wire req_write = wr_ctrl && wbyte[dea_pkg::BIT_WRITE_START];
    wire launch_write = req_write && program_enable_reg
        && (unlock_reg == dea_pkg::DEA_UNL_ARMED) && !write_start_reg;
    wire req_read = wr_ctrl && wbyte[dea_pkg::BIT_READ_START]
        && !wbyte[dea_pkg::BIT_ARRAY_SELECT];
    wire launch_read = req_read && !write_start_reg && !req_write;

    // unlock tracker
    always_comb begin
        unlock_next = unlock_reg;
        if (wreq.valid) begin
            unlock_next = dea_pkg::DEA_UNL_IDLE;
            case (unlock_reg)
                dea_pkg::DEA_UNL_IDLE: begin
                    if (wr_unlock && wbyte == dea_pkg::UNLOCK_FIRST) begin
                        unlock_next = dea_pkg::DEA_UNL_FIRST;
                    end
                end
                dea_pkg::DEA_UNL_FIRST: begin
                    if (wr_unlock && wbyte == dea_pkg::UNLOCK_SECOND) begin
                        unlock_next = dea_pkg::DEA_UNL_ARMED;
                    end else if (wr_unlock && wbyte == dea_pkg::UNLOCK_FIRST) begin
                        unlock_next = dea_pkg::DEA_UNL_FIRST;
                    end
                end
                default: begin
                    unlock_next = dea_pkg::DEA_UNL_IDLE;
                end
            endcase
        end
    end

    // read decode
    wire [7:0] ctrl_view = {array_select_reg, 3'h0, abort_reg,
        program_enable_reg, write_start_reg, read_start_reg};
    wire [7:0] rd_byte =
        (s_axi_araddr == dea_pkg::OFS_ACCESS_CONTROL) ? ctrl_view :
        (s_axi_araddr == dea_pkg::OFS_CELL_POINTER) ? cell_pointer_reg :
        (s_axi_araddr == dea_pkg::OFS_CELL_VALUE) ? cell_value_reg :
        (s_axi_araddr == dea_pkg::OFS_DONE_STATUS) ? {7'h00, done_reg} :
        8'h00;
    wire rd_ok = (s_axi_araddr == dea_pkg::OFS_ACCESS_CONTROL)
        || (s_axi_araddr == dea_pkg::OFS_UNLOCK_PORT)
        || (s_axi_araddr == dea_pkg::OFS_CELL_POINTER)
        || (s_axi_araddr == dea_pkg::OFS_CELL_VALUE)
        || (s_axi_araddr == dea_pkg::OFS_DONE_STATUS);

    dea_array #(.PROG_CYCLES(PROG_CYCLES)) u_array (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .rd_addr(cell_pointer_reg),
        .rd_data(arr_rd_data),
        .prog_start(launch_write),
        .prog_addr(cell_pointer_reg),
        .prog_data(cell_value_reg),
        .prog_busy(arr_busy),
        .prog_done(arr_done)
    );

    // bus handshake
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            awaddr_reg <= 8'h00;
            wdata_reg <= 32'h0;
            wstrb_reg <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= dea_pkg::RESP_OKAY;
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= dea_pkg::RESP_OKAY;
        end else begin
            if (aw_take) begin
                awaddr_reg <= s_axi_awaddr;
            end
            if (w_take) begin
                wdata_reg <= s_axi_wdata;
                wstrb_reg <= s_axi_wstrb;
            end
            aw_held_reg <= aw_have && !wr_fire;
            w_held_reg <= w_have && !wr_fire;
            s_axi_awready <= !aw_have && !s_axi_bvalid && !s_axi_awready;
            s_axi_wready <= !w_have && !s_axi_bvalid && !s_axi_wready;
            if (wr_fire) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= ofs_ok ? dea_pkg::RESP_OKAY : dea_pkg::RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            s_axi_arready <= !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= {24'h000000, rd_byte};
                s_axi_rresp <= rd_ok ? dea_pkg::RESP_OKAY : dea_pkg::RESP_SLVERR;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // abort flag and array select follow power-on reset only; program enable also clears on core reset
    always_ff @(posedge core_clk) begin
        if (!por_n) begin
            program_enable_reg <= 1'b0;
            abort_reg <= 1'b0;
            array_select_reg <= 1'b0;
        end else if (!rst_n) begin
            program_enable_reg <= 1'b0;
            if (ext_abort_reset && write_start_reg) begin
                abort_reg <= 1'b1;
            end
        end else if (wr_ctrl) begin
            program_enable_reg <= wbyte[dea_pkg::BIT_PROGRAM_ENABLE];
            abort_reg <= wbyte[dea_pkg::BIT_ABORT];
            if (!write_start_reg) begin
                array_select_reg <= wbyte[dea_pkg::BIT_ARRAY_SELECT];
            end
        end
    end

    // pointer and value survive a core reset so an aborted write can be retried
    always_ff @(posedge core_clk) begin
        if (!por_n) begin
            cell_pointer_reg <= 8'h00;
            cell_value_reg <= 8'h00;
        end else if (rst_n) begin
            if (wr_ptr && !write_start_reg) begin
                cell_pointer_reg <= wbyte;
            end
            if (launch_read) begin
                cell_value_reg <= arr_rd_data;
            end else if (wr_val && !write_start_reg) begin
                cell_value_reg <= wbyte;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            unlock_reg <= dea_pkg::DEA_UNL_IDLE;
            write_start_reg <= 1'b0;
            read_start_reg <= 1'b0;
            done_reg <= 1'b0;
        end else begin
            unlock_reg <= unlock_next;
            // one-cycle pulse, so the bit reads back clear by the next bus read
            read_start_reg <= launch_read;
            if (launch_write) begin
                write_start_reg <= 1'b1;
            end else if (arr_done) begin
                write_start_reg <= 1'b0;
            end
            if (arr_done) begin
                done_reg <= 1'b1;
            end else if (wr_done && wbyte[dea_pkg::BIT_DONE]) begin
                done_reg <= 1'b0;
            end
        end
    end

    a_write_needs_enable: assert property (@(posedge core_clk) disable iff (!rst_n)
        $rose(write_start_reg) |-> $past(program_enable_reg))
        else $error("write started without program enable");
    a_write_needs_unlock: assert property (@(posedge core_clk) disable iff (!rst_n)
        $rose(write_start_reg) |-> $past(unlock_reg) == dea_pkg::DEA_UNL_ARMED)
        else $error("write started without unlock");
    a_done_sets_flag: assert property (@(posedge core_clk) disable iff (!rst_n)
        arr_done |=> done_reg && !write_start_reg)
        else $error("completion did not set done or clear start");
    a_write_not_lost: assert property (@(posedge core_clk) disable iff (!rst_n)
        write_start_reg && !arr_done |=> write_start_reg)
        else $error("write start cleared early");
    a_read_value: assert property (@(posedge core_clk) disable iff (!rst_n)
        launch_read |=> cell_value_reg == $past(arr_rd_data))
        else $error("read byte not loaded");
    // value register frozen and no read pulse while a write runs
    a_no_read_in_write: assert property (@(posedge core_clk) disable iff (!rst_n)
        write_start_reg |=> $stable(cell_value_reg) && !read_start_reg)
        else $error("read during write");
    a_value_holds: assert property (@(posedge core_clk) disable iff (!rst_n)
        !launch_read && !wr_val |=> $stable(cell_value_reg))
        else $error("value changed without cause");
    a_unlock_resets: assert property (@(posedge core_clk) disable iff (!rst_n)
        wreq.valid && !wr_unlock |=> unlock_reg == dea_pkg::DEA_UNL_IDLE)
        else $error("unlock not reset");
    sequence s_read_pulse;
        read_start_reg ##1 !read_start_reg;
    endsequence
    a_read_bit_clears: assert property (@(posedge core_clk) disable iff (!rst_n)
        launch_read |=> s_read_pulse)
        else $error("read start not a single pulse");
endmodule

// [dv/tb_top.sv]
// self-checking bench for the data eeprom access controller
// assumes dea_ctrl with a shortened programming time, driven by an axi4-lite master here
`timescale 1ns/1ps
module tb_top;
    localparam logic [7:0] CTRL = dea_pkg::OFS_ACCESS_CONTROL;
    localparam logic [7:0] UNL = dea_pkg::OFS_UNLOCK_PORT;
    localparam logic [7:0] PTR = dea_pkg::OFS_CELL_POINTER;
    localparam logic [7:0] VAL = dea_pkg::OFS_CELL_VALUE;
    localparam logic [7:0] DONE = dea_pkg::OFS_DONE_STATUS;
    logic core_clk, rst_n, por_n, ext_abort_reset;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    int failures;
    int num_checks;

    dea_ctrl #(.PROG_CYCLES(20)) dea_ctrl_i (
        .core_clk(core_clk), .rst_n(rst_n), .por_n(por_n), .ext_abort_reset(ext_abort_reset),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready)
    );

    always #4 core_clk = ~core_clk;

    task automatic close_out();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic chk_val(input logic [31:0] got, input logic [31:0] exp, input string what);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp, input string what);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t: %s response %h expected %h", $time, what, got, exp);
        end
    endtask

    // address and data offered together, each dropped at its own handshake
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] er = dea_pkg::RESP_OKAY);
        int n;
        logic aw_ok, w_ok;
        n = 0;
        aw_ok = 1'h0;
        w_ok = 1'h0;
        @(posedge core_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= 4'hF;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        while (!(aw_ok && w_ok) && n < 50) begin
            @(posedge core_clk);
            n++;
            if (s_axi_awvalid && s_axi_awready === 1'h1) begin
                aw_ok = 1'h1;
                s_axi_awvalid <= 1'h0;
            end
            if (s_axi_wvalid && s_axi_wready === 1'h1) begin
                w_ok = 1'h1;
                s_axi_wvalid <= 1'h0;
            end
        end
        while (s_axi_bvalid !== 1'h1 && n < 50) begin
            @(posedge core_clk);
            n++;
        end
        s_axi_bready <= 1'h0;
        chk_resp(n < 50 ? s_axi_bresp : 2'hX, er, "write");
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d,
                      input logic [1:0] er = dea_pkg::RESP_OKAY);
        int n;
        n = 0;
        @(posedge core_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do begin
            @(posedge core_clk);
            n++;
        end while (s_axi_arready !== 1'h1 && n < 50);
        s_axi_arvalid <= 1'h0;
        while (s_axi_rvalid !== 1'h1 && n < 50) begin
            @(posedge core_clk);
            n++;
        end
        s_axi_rready <= 1'h0;
        d = s_axi_rdata;
        chk_resp(n < 50 ? s_axi_rresp : 2'hX, er, "read");
    endtask

    task automatic chk_rd(input logic [7:0] a, input logic [31:0] mask, input logic [31:0] exp,
                          input string what);
        logic [31:0] d;
        rd(a, d);
        chk_val(d & mask, exp, what);
    endtask

    task automatic unlock();
        wr(UNL, {24'h0, dea_pkg::UNLOCK_FIRST});
        wr(UNL, {24'h0, dea_pkg::UNLOCK_SECOND});
    endtask

    // polls the write start bit with a bounded number of reads
    task automatic wait_write_end();
        logic [31:0] d;
        int n;
        n = 0;
        do begin
            rd(CTRL, d);
            n++;
        end while (d[dea_pkg::BIT_WRITE_START] !== 1'h0 && n < 40);
        chk_val(d & 32'h2, 32'h0, "write start cleared on finish");
    endtask

    task automatic t_reset_map();
        logic [31:0] d;
        chk_rd(CTRL, 32'h4, 32'h0, "program enable after power-up");
        wr(UNL, 32'h55);
        chk_rd(UNL, 32'hFFFFFFFF, 32'h0, "unlock port reads zero");
        rd(8'h20, d, dea_pkg::RESP_SLVERR);
        wr(8'h20, 32'h1, dea_pkg::RESP_SLVERR);
    endtask

    task automatic t_refusals();
        wr(PTR, 32'h12);
        wr(VAL, 32'h5A);
        wr(CTRL, 32'h00);
        unlock();
        wr(CTRL, 32'h02);
        chk_rd(CTRL, 32'h2, 32'h0, "start without enable");
        wr(CTRL, 32'h04);
        wr(CTRL, 32'h06);
        chk_rd(CTRL, 32'h2, 32'h0, "start without unlock");
        wr(UNL, 32'h55);
        wr(PTR, 32'h12);
        wr(UNL, 32'hAA);
        wr(CTRL, 32'h06);
        chk_rd(CTRL, 32'h2, 32'h0, "unlock broken by other write");
        wr(UNL, 32'h55);
        wr(UNL, 32'hAB);
        wr(UNL, 32'hAA);
        wr(CTRL, 32'h06);
        chk_rd(CTRL, 32'h2, 32'h0, "unlock broken by wrong value");
    endtask

    task automatic t_write();
        unlock();
        wr(CTRL, 32'h06);
        chk_rd(CTRL, 32'h2, 32'h2, "write started");
        wr(CTRL, 32'h04);
        chk_rd(CTRL, 32'h2, 32'h2, "software cannot clear start");
        wait_write_end();
        chk_rd(DONE, 32'h1, 32'h1, "done flag set");
        chk_rd(CTRL, 32'h4, 32'h4, "enable kept after write");
        wr(DONE, 32'h1);
        chk_rd(DONE, 32'h1, 32'h0, "done flag cleared");
    endtask

    task automatic t_read();
        wr(VAL, 32'h00);
        wr(CTRL, 32'h01);
        chk_rd(VAL, 32'hFF, 32'h5A, "read byte in value");
        chk_rd(CTRL, 32'h1, 32'h0, "read start self-clears");
        wr(CTRL, 32'h00);
        chk_rd(VAL, 32'hFF, 32'h5A, "value held");
        wr(VAL, 32'h33);
        wr(CTRL, 32'h81);
        chk_rd(VAL, 32'hFF, 32'h33, "no read with program array selected");
        wr(CTRL, 32'h00);
    endtask

    task automatic t_busy();
        wr(PTR, 32'h34);
        wr(VAL, 32'hC3);
        wr(CTRL, 32'h04);
        unlock();
        wr(CTRL, 32'h06);
        wr(CTRL, 32'h00);
        wr(CTRL, 32'h01);
        chk_rd(VAL, 32'hFF, 32'hC3, "read held off while writing");
        wait_write_end();
        chk_rd(DONE, 32'h1, 32'h1, "write ran after enable cleared");
        chk_rd(CTRL, 32'h4, 32'h0, "enable as left by software");
        wr(VAL, 32'h00);
        wr(CTRL, 32'h01);
        chk_rd(VAL, 32'hFF, 32'hC3, "byte programmed");
        wr(DONE, 32'h1);
    endtask

    task automatic t_abort();
        wr(PTR, 32'h56);
        wr(VAL, 32'h77);
        wr(CTRL, 32'h04);
        unlock();
        wr(CTRL, 32'h06);
        @(posedge core_clk);
        rst_n <= 1'h0;
        ext_abort_reset <= 1'h1;
        repeat (3) @(posedge core_clk);
        rst_n <= 1'h1;
        ext_abort_reset <= 1'h0;
        chk_rd(CTRL, 32'h8, 32'h8, "abort flag");
        chk_rd(PTR, 32'hFF, 32'h56, "pointer kept");
        chk_rd(VAL, 32'hFF, 32'h77, "value kept");
    endtask

    initial begin
        core_clk = 1'h0;
        rst_n = 1'h0;
        por_n = 1'h0;
        ext_abort_reset = 1'h0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        failures = 0;
        num_checks = 0;
        repeat (6) @(posedge core_clk);
        rst_n <= 1'h1;
        por_n <= 1'h1;
        t_reset_map();
        t_refusals();
        t_write();
        t_read();
        t_busy();
        t_abort();
        close_out();
    end

    // the whole run needs well under 3000 cycles
    initial begin
        repeat (20000) @(posedge core_clk);
        failures++;
        $display("unexpected at %0t: watchdog expired", $time);
        close_out();
    end
endmodule
